// ---- sim/srsr_host.sv ----
// Host model issuing status commands and collecting answers
`timescale 1ns/1ps
module srsr_host
(
	// Clock
	input  wire logic              clk,
	// Commands toward the block
	output logic                   cmdValid,
	output srsr_pkg::srsr_op_type  cmdOp,
	output srsr_pkg::srsr_sel_type cmdSel,
	output logic                   cmdHasIndex,
	output logic [2:0]             cmdIndex,
	output logic                   cmdBit,
	output logic [7:0]             cmdData,
	// Answers
	input  wire logic              rspValid,
	input  wire logic [7:0]        rspData
);
	import srsr_pkg::*;

	// Idle bus at time zero
	initial
	begin
		cmdValid = 1'b0;
		cmdOp = SRSR_OP_QUERY;
		cmdSel = SRSR_SEL_STD_STATUS;
		{cmdHasIndex, cmdIndex, cmdBit, cmdData} = 13'h0;
	end

	// One strobe per call; index, bit and data fields inverted after release (op and select held) so stale values are never trusted
	task automatic send(input srsr_op_type o, input srsr_sel_type s, input logic [7:0] d,
		input logic [2:0] i, input logic b, input logic h);
		@(negedge clk);
		cmdOp = o;
		cmdSel = s;
		cmdData = d;
		cmdIndex = i;
		cmdBit = b;
		cmdHasIndex = h;
		cmdValid = 1'b1;
		@(negedge clk);
		cmdValid = 1'b0;
		{cmdHasIndex, cmdIndex, cmdBit, cmdData} = ~{cmdHasIndex, cmdIndex, cmdBit, cmdData};
	endtask

	// Answer due one cycle after the command is taken; short bounded grace
	task automatic query(input srsr_sel_type s, input logic h, input logic [2:0] i,
		output logic [7:0] d, output logic ok);
		int n;
		send(SRSR_OP_QUERY, s, 8'h00, i, 1'b0, h);
		n = 0;
		while (rspValid !== 1'b1 && n < 3)
		begin
			@(negedge clk);
			n++;
		end
		ok = (rspValid === 1'b1);
		d = rspData;
	endtask
endmodule

// ---- sim/test_srsr_status.sv ----
// Self-checking bench for the status reporting block
`timescale 1ns/1ps
module test_srsr_status;
	import srsr_pkg::*;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic         cmdValid, cmdHasIndex, cmdBit, rspValid, pscFlag, serviceRequest;
	srsr_op_type  cmdOp;
	srsr_sel_type cmdSel;
	logic [2:0]   cmdIndex;
	logic [7:0]   cmdData, rspData, serialPollSummary;
	logic         serialPoll = 1'b0, restoreLoad = 1'b0, restorePsc = 1'b0;
	logic [2:0]   lvl = 3'h0;
	logic [4:0]   evt = 5'h0;
	logic [6:0]   measEvent = 7'h00;
	logic [7:0]   faultEvent = 8'h00, rStd = 8'h00, rSp = 8'h00, rFault = 8'h00, rMeas = 8'h00;
	int           n_mismatch = 0;
	int           n_tests = 0;
	localparam logic [2:0] EV_IDX [5] = '{3'd0, 3'd2, 3'd4, 3'd5, 3'd6};
	localparam logic [2:0] LV_IDX [3] = '{3'd0, 3'd1, 3'd4};

	// Clock, 4 ns period
	always #2 clk = ~clk;

	srsr_host u_srsr_host
	(
		.clk(clk), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel),
		.cmdHasIndex(cmdHasIndex), .cmdIndex(cmdIndex), .cmdBit(cmdBit),
		.cmdData(cmdData), .rspValid(rspValid), .rspData(rspData)
	);

	srsr_status u_srsr_status
	(
		.clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel),
		.cmdHasIndex(cmdHasIndex), .cmdIndex(cmdIndex), .cmdBit(cmdBit), .cmdData(cmdData),
		.serialPoll(serialPoll), .rspValid(rspValid), .rspData(rspData),
		.acquisitionIdle(lvl[0]), .commandIdle(lvl[1]), .outputAvailable(lvl[2]),
		.inputQueueOverflow(evt[0]), .outputQueueOverflow(evt[1]), .execError(evt[2]),
		.illegalCommand(evt[3]), .userRequest(evt[4]), .measEvent(measEvent),
		.faultEvent(faultEvent), .restoreLoad(restoreLoad), .restorePsc(restorePsc),
		.restoreStdEnable(rStd), .restoreSpEnable(rSp), .restoreFaultEnable(rFault),
		.restoreMeasEnable(rMeas), .pscFlag(pscFlag), .serviceRequest(serviceRequest),
		.serialPollSummary(serialPollSummary)
	);

	// Verdict and end of run
	task automatic summarize();
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			n_mismatch++;
		end
	endtask

	// A missing answer ends the run at once
	task automatic q(input srsr_sel_type s, input logic h, input logic [2:0] i,
		input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		u_srsr_host.query(s, h, i, d, ok);
		chk({7'h0, ok}, 8'h01);
		if (ok !== 1'b1)
			summarize();
		chk(d, e);
	endtask

	task automatic wr(input srsr_sel_type s, input logic [7:0] d);
		u_srsr_host.send(SRSR_OP_WRITE_BYTE, s, d, 3'h0, 1'b0, 1'b0);
	endtask

	task automatic wb(input srsr_sel_type s, input logic [2:0] i, input logic b);
		u_srsr_host.send(SRSR_OP_WRITE_BIT, s, 8'h00, i, b, 1'b0);
	endtask

	task automatic clr();
		u_srsr_host.send(SRSR_OP_CLEAR, SRSR_SEL_STD_STATUS, 8'h00, 3'h0, 1'b0, 1'b0);
	endtask

	// Main sequence
	initial
	begin
		int n;
		tick(3);
		chk({5'h0, serviceRequest, rspValid, pscFlag}, 8'h01);
		reset = 1'b0;
		tick(2);
		q(SRSR_SEL_STD_STATUS, 1'b0, 3'h0, 8'h80);
		wr(SRSR_SEL_STD_ENABLE, 8'ha5);
		q(SRSR_SEL_STD_ENABLE, 1'b0, 3'h0, 8'ha5);
		wb(SRSR_SEL_STD_ENABLE, 3'h1, 1'b1);
		q(SRSR_SEL_STD_ENABLE, 1'b0, 3'h0, 8'ha7);
		q(SRSR_SEL_STD_ENABLE, 1'b1, 3'h1, 8'h01);
		q(SRSR_SEL_STD_ENABLE, 1'b1, 3'h3, 8'h00);
		chk(serialPollSummary, 8'h20);
		wr(SRSR_SEL_STD_STATUS, 8'h00);
		q(SRSR_SEL_STD_STATUS, 1'b1, 3'h7, 8'h01);
		// Each event alone after a clear lands on its own bit
		for (n = 0; n < 5; n++)
		begin
			clr();
			evt = 5'h01 << n;
			tick(1);
			evt = 5'h00;
			q(SRSR_SEL_STD_STATUS, 1'b0, 3'h0, 8'h01 << EV_IDX[n]);
			q(SRSR_SEL_STD_STATUS, 1'b1, EV_IDX[n], 8'h01);
		end
		clr();
		wr(SRSR_SEL_STD_ENABLE, 8'h00);
		// Idle and buffer levels feed the poll byte directly
		for (n = 0; n < 3; n++)
		begin
			lvl = 3'h1 << n;
			tick(2);
			chk(serialPollSummary, 8'h01 << LV_IDX[n]);
			q(SRSR_SEL_SP_STATUS, 1'b0, 3'h0, 8'h01 << LV_IDX[n]);
		end
		q(SRSR_SEL_SP_STATUS, 1'b1, 3'h4, 8'h01);
		lvl = 3'h0;
		wr(SRSR_SEL_FAULT_ENABLE, 8'h80);
		wb(SRSR_SEL_FAULT_ENABLE, 3'h1, 1'b1);
		q(SRSR_SEL_FAULT_ENABLE, 1'b0, 3'h0, 8'h82);
		q(SRSR_SEL_FAULT_ENABLE, 1'b1, 3'h7, 8'h01);
		// Fault bits 0 and 3 have no source
		faultEvent = 8'h09;
		tick(1);
		faultEvent = 8'h02;
		tick(1);
		faultEvent = 8'h00;
		q(SRSR_SEL_FAULT_STATUS, 1'b0, 3'h0, 8'h02);
		q(SRSR_SEL_FAULT_STATUS, 1'b1, 3'h1, 8'h01);
		wb(SRSR_SEL_MEAS_ENABLE, 3'h6, 1'b1);
		measEvent = 7'h41;
		tick(1);
		measEvent = 7'h00;
		q(SRSR_SEL_MEAS_STATUS, 1'b0, 3'h0, 8'h41);
		chk(serialPollSummary, 8'h0c);
		wr(SRSR_SEL_SP_ENABLE, 8'h0c);
		wb(SRSR_SEL_SP_ENABLE, 3'h2, 1'b0);
		q(SRSR_SEL_SP_ENABLE, 1'b0, 3'h0, 8'h08);
		q(SRSR_SEL_SP_ENABLE, 1'b1, 3'h3, 8'h01);
		// Request must appear within a few cycles of an enabled poll bit
		n = 0;
		while (serviceRequest !== 1'b1 && n < 8)
		begin
			tick(1);
			n++;
		end
		chk({7'h0, serviceRequest}, 8'h01);
		// A request that never came ends the run here
		if (serviceRequest !== 1'b1)
			summarize();
		tick(1);
		chk(serialPollSummary, 8'h4c);
		serialPoll = 1'b1;
		tick(1);
		serialPoll = 1'b0;
		chk({7'h0, serviceRequest}, 8'h00);
		clr();
		tick(2);
		chk({serviceRequest, serialPollSummary[6:0]}, 8'h00);
		q(SRSR_SEL_MEAS_STATUS, 1'b0, 3'h0, 8'h00);
		wr(SRSR_SEL_MEAS_ENABLE, 8'h5a);
		q(SRSR_SEL_MEAS_ENABLE, 1'b0, 3'h0, 8'h5a);
		wr(SRSR_SEL_PSC, 8'h00);
		wb(SRSR_SEL_PSC, 3'h0, 1'b1);
		q(SRSR_SEL_PSC, 1'b0, 3'h0, 8'h00);
		chk({7'h0, pscFlag}, 8'h00);
		wr(SRSR_SEL_PSC, 8'h01);
		q(SRSR_SEL_PSC, 1'b0, 3'h0, 8'h01);
		// Retained masks survive only while the clear option is off
		{rStd, rSp, rFault, rMeas} = 32'h3c11f00f;
		for (n = 0; n < 2; n++)
		begin
			restorePsc = (n == 1);
			restoreLoad = 1'b1;
			tick(1);
			restoreLoad = 1'b0;
			q(SRSR_SEL_STD_ENABLE, 1'b0, 3'h0, (n == 1) ? 8'h00 : 8'h3c);
			q(SRSR_SEL_MEAS_ENABLE, 1'b0, 3'h0, (n == 1) ? 8'h00 : 8'h0f);
		end
		summarize();
	end
endmodule

// ---- src/srsr_params.svh ----
// Bit positions, event masks and reset values of the status reporting block
`ifndef SRSR_PARAMS_SVH
`define SRSR_PARAMS_SVH

// Serial poll summary byte
`define SRSR_SP_ACQ_IDLE   0
`define SRSR_SP_CMD_IDLE   1
`define SRSR_SP_FAULT      2
`define SRSR_SP_MEAS       3
`define SRSR_SP_OUT_AVAIL  4
`define SRSR_SP_STD_EVENT  5
`define SRSR_SP_SRQ        6

// Standard event flags
`define SRSR_SE_IN_OVF     0
`define SRSR_SE_OUT_OVF    2
`define SRSR_SE_EXEC_ERR   4
`define SRSR_SE_ILLEGAL    5
`define SRSR_SE_USER_REQ   6
`define SRSR_SE_POWER_ON   7

// Bits that events can set in the standard, fault and measurement status bytes
`define SRSR_SE_USED       8'hf5
`define SRSR_FAULT_USED    8'hf6
`define SRSR_MEAS_USED     8'h7f

// Reset values
`define SRSR_MASK_RESET    8'h00
`define SRSR_PSC_RESET     1'b1

`endif

// ---- src/srsr_pkg.sv ----
// Types shared by the status reporting block and its users
package srsr_pkg;

	// Host command kind
	typedef enum logic [1:0] {
		SRSR_OP_CLEAR,
		SRSR_OP_WRITE_BYTE,
		SRSR_OP_WRITE_BIT,
		SRSR_OP_QUERY
	} srsr_op_type;

	// Byte addressed by a command
	typedef enum logic [3:0] {
		SRSR_SEL_STD_ENABLE,
		SRSR_SEL_STD_STATUS,
		SRSR_SEL_SP_ENABLE,
		SRSR_SEL_SP_STATUS,
		SRSR_SEL_PSC,
		SRSR_SEL_FAULT_ENABLE,
		SRSR_SEL_FAULT_STATUS,
		SRSR_SEL_MEAS_ENABLE,
		SRSR_SEL_MEAS_STATUS
	} srsr_sel_type;

endpackage

// ---- src/srsr_status.sv ----
// Status bytes, enable masks, serial poll summary and service request
`timescale 1ns/1ps
`include "srsr_params.svh"
module srsr_status
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// Host command port
	input  wire logic                 cmdValid,
	input  wire srsr_pkg::srsr_op_type  cmdOp,
	input  wire srsr_pkg::srsr_sel_type cmdSel,
	input  wire logic                 cmdHasIndex,
	input  wire logic [2:0]           cmdIndex,
	input  wire logic                 cmdBit,
	input  wire logic [7:0]           cmdData,
	input  wire logic                 serialPoll,
	// Query answer
	output logic                      rspValid,
	output logic [7:0]                rspData,
	// Instrument events and levels
	input  wire logic                 acquisitionIdle,
	input  wire logic                 commandIdle,
	input  wire logic                 outputAvailable,
	input  wire logic                 inputQueueOverflow,
	input  wire logic                 outputQueueOverflow,
	input  wire logic                 execError,
	input  wire logic                 illegalCommand,
	input  wire logic                 userRequest,
	input  wire logic [6:0]           measEvent,
	input  wire logic [7:0]           faultEvent,
	// Retained settings restore, and power-on clear flag for saving
	input  wire logic                 restoreLoad,
	input  wire logic                 restorePsc,
	input  wire logic [7:0]           restoreStdEnable,
	input  wire logic [7:0]           restoreSpEnable,
	input  wire logic [7:0]           restoreFaultEnable,
	input  wire logic [7:0]           restoreMeasEnable,
	output logic                      pscFlag,
	// Service request line and summary byte
	output logic                      serviceRequest,
	output logic [7:0]                serialPollSummary
);
	import srsr_pkg::*;

	logic [7:0] stdEnable_q, stdEnable_d;
	logic [7:0] spEnable_q, spEnable_d;
	logic [7:0] faultEnable_q, faultEnable_d;
	logic [7:0] measEnable_q, measEnable_d;
	logic       psc_q, psc_d;
	logic [7:0] standardEventFlags_q, standardEventFlags_d;
	logic [7:0] faultFlags_q, faultFlags_d;
	logic [7:0] measFlags_q, measFlags_d;
	logic       srq_q, srq_d;
	logic       powerUp_q;
	logic       rspValid_q, rspValid_d;
	logic [7:0] rspData_q, rspData_d;
	logic [7:0] spSummary_q;
	logic [7:0] spNow;
	logic [7:0] stdSet, qByte;
	logic       wrByte, wrBit, doClear, reqLevel;

	// Decoded command strobes
	assign doClear = cmdValid && cmdOp == SRSR_OP_CLEAR;
	assign wrByte  = cmdValid && cmdOp == SRSR_OP_WRITE_BYTE;
	assign wrBit   = cmdValid && cmdOp == SRSR_OP_WRITE_BIT;

	// Event sources of the standard byte; power-up flag fires once after reset
	always_comb
	begin
		stdSet = 8'h00;
		stdSet[`SRSR_SE_IN_OVF]   = inputQueueOverflow;
		stdSet[`SRSR_SE_OUT_OVF]  = outputQueueOverflow;
		stdSet[`SRSR_SE_EXEC_ERR] = execError;
		stdSet[`SRSR_SE_ILLEGAL]  = illegalCommand;
		stdSet[`SRSR_SE_USER_REQ] = userRequest;
		stdSet[`SRSR_SE_POWER_ON] = powerUp_q;
	end

	// Live serial poll byte; bits 0,1,4 follow their levels directly
	always_comb
	begin
		spNow = 8'h00;
		spNow[`SRSR_SP_ACQ_IDLE]  = acquisitionIdle;
		spNow[`SRSR_SP_CMD_IDLE]  = commandIdle;
		spNow[`SRSR_SP_FAULT]     = |(faultFlags_q & faultEnable_q);
		spNow[`SRSR_SP_MEAS]      = |(measFlags_q & measEnable_q);
		spNow[`SRSR_SP_OUT_AVAIL] = outputAvailable;
		spNow[`SRSR_SP_STD_EVENT] = |(standardEventFlags_q & stdEnable_q);
		spNow[`SRSR_SP_SRQ]       = srq_q;
	end

	// Service is wanted by any enabled poll bit other than the request bit itself
	assign reqLevel = |(spNow[5:0] & spEnable_q[5:0]);

	// Enable masks and the power-on clear flag
	always_comb
	begin
		stdEnable_d   = stdEnable_q;
		spEnable_d    = spEnable_q;
		faultEnable_d = faultEnable_q;
		measEnable_d  = measEnable_q;
		psc_d         = psc_q;
		if (restoreLoad)
		begin
			// Masks survive a power cycle only while the flag is clear
			psc_d         = restorePsc;
			stdEnable_d   = restorePsc ? `SRSR_MASK_RESET : restoreStdEnable;
			spEnable_d    = restorePsc ? `SRSR_MASK_RESET : restoreSpEnable;
			faultEnable_d = restorePsc ? `SRSR_MASK_RESET : restoreFaultEnable;
			measEnable_d  = restorePsc ? `SRSR_MASK_RESET : restoreMeasEnable;
		end
		else if (wrByte)
		begin
			unique case (cmdSel)
				SRSR_SEL_STD_ENABLE:   stdEnable_d   = cmdData;
				SRSR_SEL_SP_ENABLE:    spEnable_d    = cmdData;
				SRSR_SEL_FAULT_ENABLE: faultEnable_d = cmdData;
				SRSR_SEL_MEAS_ENABLE:  measEnable_d  = cmdData;
				SRSR_SEL_PSC:          psc_d         = cmdData[0];
				default:               ;
			endcase
		end
		else if (wrBit)
		begin
			unique case (cmdSel)
				SRSR_SEL_STD_ENABLE:   stdEnable_d[cmdIndex]   = cmdBit;
				SRSR_SEL_SP_ENABLE:    spEnable_d[cmdIndex]    = cmdBit;
				SRSR_SEL_FAULT_ENABLE: faultEnable_d[cmdIndex] = cmdBit;
				SRSR_SEL_MEAS_ENABLE:  measEnable_d[cmdIndex]  = cmdBit;
				default:               ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stdEnable_q   <= `SRSR_MASK_RESET;
			spEnable_q    <= `SRSR_MASK_RESET;
			faultEnable_q <= `SRSR_MASK_RESET;
			measEnable_q  <= `SRSR_MASK_RESET;
			psc_q         <= `SRSR_PSC_RESET;
		end
		else
		begin
			stdEnable_q   <= stdEnable_d;
			spEnable_q    <= spEnable_d;
			faultEnable_q <= faultEnable_d;
			measEnable_q  <= measEnable_d;
			psc_q         <= psc_d;
		end
	end

	// Sticky status bytes; a new event in the clearing cycle is kept
	always_comb
	begin
		standardEventFlags_d = doClear ? 8'h00 : standardEventFlags_q;
		faultFlags_d         = doClear ? 8'h00 : faultFlags_q;
		measFlags_d          = doClear ? 8'h00 : measFlags_q;
		standardEventFlags_d = standardEventFlags_d | (stdSet & `SRSR_SE_USED);
		faultFlags_d = faultFlags_d | (faultEvent & `SRSR_FAULT_USED);
		measFlags_d  = measFlags_d | ({1'b0, measEvent} & `SRSR_MEAS_USED);
		// Request latches on service need; poll or clear drops it, and it latches again next cycle if still needed
		srq_d = srq_q;
		if (doClear || serialPoll)
			srq_d = 1'b0;
		if (reqLevel && !srq_q)
			srq_d = 1'b1;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			standardEventFlags_q <= 8'h00;
			faultFlags_q         <= 8'h00;
			measFlags_q          <= 8'h00;
			srq_q                <= 1'b0;
			powerUp_q            <= 1'b1;
		end
		else
		begin
			standardEventFlags_q <= standardEventFlags_d;
			faultFlags_q         <= faultFlags_d;
			measFlags_q          <= measFlags_d;
			srq_q                <= srq_d;
			powerUp_q            <= 1'b0;
		end
	end

	// Query answer: whole byte, or the named bit alone in bit 0
	always_comb
	begin
		unique case (cmdSel)
			SRSR_SEL_STD_ENABLE:   qByte = stdEnable_q;
			SRSR_SEL_STD_STATUS:   qByte = standardEventFlags_q;
			SRSR_SEL_SP_ENABLE:    qByte = spEnable_q;
			SRSR_SEL_SP_STATUS:    qByte = spNow;
			SRSR_SEL_PSC:          qByte = {7'h00, psc_q};
			SRSR_SEL_FAULT_ENABLE: qByte = faultEnable_q;
			SRSR_SEL_FAULT_STATUS: qByte = faultFlags_q;
			SRSR_SEL_MEAS_ENABLE:  qByte = measEnable_q;
			SRSR_SEL_MEAS_STATUS:  qByte = measFlags_q;
			default:               qByte = 8'h00;
		endcase
		rspValid_d = cmdValid && cmdOp == SRSR_OP_QUERY;
		rspData_d  = rspData_q;
		if (rspValid_d)
			rspData_d = cmdHasIndex ? {7'h00, qByte[cmdIndex]} : qByte;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rspValid_q  <= 1'b0;
			rspData_q   <= 8'h00;
			spSummary_q <= 8'h00;
		end
		else
		begin
			rspValid_q  <= rspValid_d;
			rspData_q   <= rspData_d;
			spSummary_q <= spNow;
		end
	end

	// Outputs straight from flip-flops
	assign rspValid          = rspValid_q;
	assign rspData           = rspData_q;
	assign pscFlag           = psc_q;
	assign serviceRequest    = srq_q;
	assign serialPollSummary = spSummary_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_clear;
		cmdValid && cmdOp == SRSR_OP_CLEAR && faultEvent == 8'h00 && measEvent == 7'h00
			&& stdSet == 8'h00
			|=> faultFlags_q == 8'h00 && measFlags_q == 8'h00
				&& standardEventFlags_q == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("status not cleared");

	property p_bit_query;
		cmdValid && cmdOp == SRSR_OP_QUERY && cmdHasIndex |=> rspValid && rspData[7:1] == 7'h00;
	endproperty
	a_bit_query: assert property (p_bit_query) else $error("bit query not single bit");

	property p_std_write;
		cmdValid && cmdOp == SRSR_OP_WRITE_BYTE && cmdSel == SRSR_SEL_STD_ENABLE && !restoreLoad
			|=> stdEnable_q == $past(cmdData);
	endproperty
	a_std_write: assert property (p_std_write) else $error("enable byte not written");

	property p_psc;
		cmdValid && cmdOp == SRSR_OP_WRITE_BYTE && cmdSel == SRSR_SEL_PSC && !restoreLoad
			|=> pscFlag == $past(cmdData[0]);
	endproperty
	a_psc: assert property (p_psc) else $error("power-on clear flag wrong");

	property p_idle;
		##1 serialPollSummary[1:0] == $past({commandIdle, acquisitionIdle});
	endproperty
	a_idle: assert property (p_idle) else $error("idle bits wrong");

	property p_fault_sum;
		|(faultFlags_q & faultEnable_q) |=> serialPollSummary[2];
	endproperty
	a_fault_sum: assert property (p_fault_sum) else $error("fault summary missing");

	property p_std_event;
		execError |=> standardEventFlags_q[4];
	endproperty
	a_std_event: assert property (p_std_event) else $error("execution error not flagged");

	property p_srq;
		reqLevel && !srq_q |=> serviceRequest ##1 serialPollSummary[6];
	endproperty
	a_srq: assert property (p_srq) else $error("service request not raised");

	property p_unused;
		standardEventFlags_q[1] == 1'b0 && standardEventFlags_q[3] == 1'b0 && !spNow[7];
	endproperty
	a_unused: assert property (p_unused) else $error("unused bit set");
endmodule
